// >>> ihc_pkg.sv
// constants for the host bus control register block
package ihc_pkg;
	localparam int DW = 24;
	localparam int AW = 8;
	localparam logic [7:0] OFF_DEV_CTRL = 8'h00;
	localparam logic [7:0] OFF_HOST_CFG = 8'h01;
	localparam logic [7:0] OFF_HOST_XFER = 8'h03;
	localparam logic [23:0] RST_DEV_CTRL = 24'h000000;
	localparam logic [23:0] RST_HOST_CFG = 24'h120140;
	localparam logic [23:0] RST_HOST_XFER = 24'h000000;
	localparam logic [23:0] MASK_DEV_CTRL = 24'hE00041;
	localparam logic [23:0] MASK_HOST_CFG = 24'h3E01FE;
	localparam logic [23:0] MASK_HOST_XFER = 24'h020000;
	localparam int B_SINGLE_CAP = 23;
	localparam int B_FORCE_LOCAL = 22;
	localparam int B_PASSTHRU = 21;
	localparam int B_BURST = 6;
	localparam int B_SOFT_RST = 0;
	localparam int B_DIR_LO = 20;
	localparam int B_DIR_HI = 21;
	localparam int B_HOST_EN = 19;
	localparam int B_MAN_TRIG = 18;
	localparam int B_SAMPLE_TRIG = 17;
	localparam int B_EE_ADDR_LO = 2;
	localparam int B_EE_ADDR_HI = 8;
	localparam int B_SWAP = 1;
	localparam int B_NUM_TRAN = 17;
	localparam int B_RESULT_HI = 7;
	typedef enum logic [1:0] {
		IHC_IDLE,
		IHC_ISSUE,
		IHC_WAIT
	} ihc_seq_t;
endpackage

// >>> ihc_host_seq.sv
// host bus transaction sequencer with read-byte capture
`timescale 1ns/10ps
`default_nettype none
module ihc_host_seq (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic       soft_rst,
	input  wire logic       trigger,
	input  wire logic       allowed,
	input  wire logic       two_trans,
	input  wire logic [1:0] dir,
	input  wire logic       swap,
	input  wire logic       xfer_done,
	input  wire logic [7:0] xfer_rdata,
	output logic            xfer_start,
	output logic            xfer_read,
	output logic            xfer_index,
	output logic            busy,
	output logic [7:0]      result
);
	ihc_pkg::ihc_seq_t state_reg, state_next;
	logic       idx_reg, idx_next;
	logic       start_reg, start_next;
	logic       read_reg, read_next;
	logic [7:0] res_reg, res_next;
	logic       busy_reg, busy_next;

	function automatic logic [7:0] rev8(input logic [7:0] d);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			r[i] = d[7 - i];
		end
		return r;
	endfunction

	always_comb begin
		state_next = state_reg;
		idx_next = idx_reg;
		start_next = 1'b0;
		read_next = read_reg;
		res_next = res_reg;
		case (state_reg)
			ihc_pkg::IHC_IDLE: begin
				if (trigger && allowed) begin
					idx_next = 1'b0;
					state_next = ihc_pkg::IHC_ISSUE;
				end
			end
			ihc_pkg::IHC_ISSUE: begin
				start_next = 1'b1;
				read_next = dir[idx_reg];
				state_next = ihc_pkg::IHC_WAIT;
			end
			ihc_pkg::IHC_WAIT: begin
				if (xfer_done) begin
					if (read_reg) begin
						res_next = swap ? rev8(xfer_rdata) : xfer_rdata;
					end
					if (two_trans && !idx_reg) begin
						idx_next = 1'b1;
						state_next = ihc_pkg::IHC_ISSUE;
					end else begin
						state_next = ihc_pkg::IHC_IDLE;
					end
				end
			end
			default: state_next = ihc_pkg::IHC_IDLE;
		endcase
		if (soft_rst) begin
			state_next = ihc_pkg::IHC_IDLE;
			idx_next = 1'b0;
			start_next = 1'b0;
			read_next = 1'b0;
			res_next = '0;
		end
		busy_next = (state_next != ihc_pkg::IHC_IDLE);
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg <= ihc_pkg::IHC_IDLE;
			idx_reg <= 1'b0;
			start_reg <= 1'b0;
			read_reg <= 1'b0;
			res_reg <= '0;
			busy_reg <= 1'b0;
		end else if (ce) begin
			state_reg <= state_next;
			idx_reg <= idx_next;
			start_reg <= start_next;
			read_reg <= read_next;
			res_reg <= res_next;
			busy_reg <= busy_next;
		end
	end

	assign xfer_start = start_reg;
	assign xfer_read = read_reg;
	assign xfer_index = idx_reg;
	assign busy = busy_reg;
	assign result = res_reg;
endmodule
`default_nettype wire

// >>> ihc_ctrl_regs.sv
// control registers for capture, soft reset and the host bus
//
// Contract
// - writing 1 starts one capture; bit self-clears once capture completes
// - force-local bit lets own host reach target registers at any address
// - passthrough bit disables own host and joins host and target buses
// - burst bit allows continuous multi-register access on the target port
// - writing soft reset restores every register default, including itself
// - direction field: 0 write, 1 read; low bit first transaction; reset 1
// - host starts a sequence only while host enable is 1; reset 0
// - manual trigger bit launches host sequence when per-sample trigger off
// - per-sample trigger (reset 1) launches host at each sample start
// - seven-bit eeprom address field, reset 50h, drives host bus address
// - bit-reverse bit reverses each byte the host reads
// - transaction count bit: 0 one transaction, 1 two transactions
// - host read byte appears in read-only result field
`timescale 1ns/10ps
`default_nettype none
module ihc_ctrl_regs (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [23:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic        sample_start,
	input  wire logic        capture_done,
	input  wire logic        xfer_done,
	input  wire logic [7:0]  xfer_rdata,
	output logic [23:0]      reg_rdata,
	output logic             capture_start,
	output logic             soft_reset_out,
	output logic             burst_register_access,
	output logic             force_local_access,
	output logic             bus_passthrough,
	output logic [6:0]       eeprom_addr,
	output logic             xfer_start,
	output logic             xfer_read,
	output logic             xfer_index,
	output logic             host_busy
);
	logic [23:0] dev_reg, dev_next;
	logic [23:0] cfg_reg, cfg_next;
	logic [23:0] xfr_reg, xfr_next;
	logic [23:0] rdata_reg, rdata_next;
	logic        cap_reg, cap_next;
	logic        srst_reg, srst_next;
	logic        trig_pulse;
	logic        host_trig;
	logic        allowed;
	logic [7:0]  result;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	always_comb begin
		dev_next = dev_reg;
		cfg_next = cfg_reg;
		xfr_next = xfr_reg;
		rdata_next = rdata_reg;
		cap_next = 1'b0;
		srst_next = 1'b0;
		// manual trigger lives one cycle, a refused one is dropped
		trig_pulse = cfg_reg[ihc_pkg::B_MAN_TRIG];
		cfg_next[ihc_pkg::B_MAN_TRIG] = 1'b0;
		if (capture_done) begin
			dev_next[ihc_pkg::B_SINGLE_CAP] = 1'b0;
		end
		if (reg_wr && hit(reg_addr, ihc_pkg::OFF_DEV_CTRL)) begin
			dev_next = reg_wdata & ihc_pkg::MASK_DEV_CTRL;
			cap_next = reg_wdata[ihc_pkg::B_SINGLE_CAP];
			srst_next = reg_wdata[ihc_pkg::B_SOFT_RST];
			dev_next[ihc_pkg::B_SOFT_RST] = 1'b0;
		end
		if (reg_wr && hit(reg_addr, ihc_pkg::OFF_HOST_CFG)) begin
			cfg_next = reg_wdata & ihc_pkg::MASK_HOST_CFG;
		end
		if (reg_wr && hit(reg_addr, ihc_pkg::OFF_HOST_XFER)) begin
			xfr_next = (reg_wdata & ihc_pkg::MASK_HOST_XFER) | {16'h0000, result};
		end else begin
			xfr_next[ihc_pkg::B_RESULT_HI:0] = result;
		end
		if (reg_rd) begin
			if (hit(reg_addr, ihc_pkg::OFF_DEV_CTRL)) begin
				rdata_next = dev_reg;
			end else if (hit(reg_addr, ihc_pkg::OFF_HOST_CFG)) begin
				rdata_next = cfg_reg;
			end else if (hit(reg_addr, ihc_pkg::OFF_HOST_XFER)) begin
				rdata_next = xfr_reg;
			end else begin
				rdata_next = 24'h000000;
			end
		end
		if (srst_reg) begin
			dev_next = ihc_pkg::RST_DEV_CTRL;
			cfg_next = ihc_pkg::RST_HOST_CFG;
			xfr_next = ihc_pkg::RST_HOST_XFER;
			cap_next = 1'b0;
			trig_pulse = 1'b0;
		end
		host_trig = cfg_reg[ihc_pkg::B_SAMPLE_TRIG] ? sample_start
			: trig_pulse;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			dev_reg <= ihc_pkg::RST_DEV_CTRL;
			cfg_reg <= ihc_pkg::RST_HOST_CFG;
			xfr_reg <= ihc_pkg::RST_HOST_XFER;
			rdata_reg <= 24'h000000;
			cap_reg <= 1'b0;
			srst_reg <= 1'b0;
		end else if (ce) begin
			dev_reg <= dev_next;
			cfg_reg <= cfg_next;
			xfr_reg <= xfr_next;
			rdata_reg <= rdata_next;
			cap_reg <= cap_next;
			srst_reg <= srst_next;
		end
	end

	// host starts only when enabled and not bypassed
	assign allowed = cfg_reg[ihc_pkg::B_HOST_EN]
		&& !dev_reg[ihc_pkg::B_PASSTHRU];

	ihc_host_seq u_seq (
		.mclk       (mclk),
		.rst        (rst),
		.ce         (ce),
		.soft_rst   (srst_reg),
		.trigger    (host_trig),
		.allowed    (allowed),
		.two_trans  (xfr_reg[ihc_pkg::B_NUM_TRAN]),
		.dir        (cfg_reg[ihc_pkg::B_DIR_HI:ihc_pkg::B_DIR_LO]),
		.swap       (cfg_reg[ihc_pkg::B_SWAP]),
		.xfer_done  (xfer_done),
		.xfer_rdata (xfer_rdata),
		.xfer_start (xfer_start),
		.xfer_read  (xfer_read),
		.xfer_index (xfer_index),
		.busy       (host_busy),
		.result     (result)
	);

	assign reg_rdata = rdata_reg;
	assign capture_start = cap_reg;
	assign soft_reset_out = srst_reg;
	assign burst_register_access = dev_reg[ihc_pkg::B_BURST];
	assign force_local_access = dev_reg[ihc_pkg::B_FORCE_LOCAL];
	assign bus_passthrough = dev_reg[ihc_pkg::B_PASSTHRU];
	assign eeprom_addr =
		cfg_reg[ihc_pkg::B_EE_ADDR_HI:ihc_pkg::B_EE_ADDR_LO];

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	chk_soft_reset_cfg: assert property (
		srst_reg && ce |=> cfg_reg == ihc_pkg::RST_HOST_CFG)
		else $error("soft reset did not restore config");
	chk_soft_reset_dev: assert property (
		reg_wr && ce && reg_addr == ihc_pkg::OFF_DEV_CTRL
		&& reg_wdata[ihc_pkg::B_SOFT_RST] ##1 ce
		|=> dev_reg == ihc_pkg::RST_DEV_CTRL)
		else $error("soft reset not applied");
	chk_cap_pulse: assert property (
		capture_start && $past(ce) |-> $past(reg_wr)
		&& $past(reg_addr) == ihc_pkg::OFF_DEV_CTRL
		&& $past(reg_wdata[ihc_pkg::B_SINGLE_CAP]))
		else $error("capture start without write");
	chk_cap_clear: assert property (
		capture_done && ce && !reg_wr && !srst_reg
		|=> !dev_reg[ihc_pkg::B_SINGLE_CAP])
		else $error("single capture bit not cleared");
	chk_host_gated: assert property (
		$rose(host_busy) |-> $past(allowed))
		else $error("host started while disabled");
	chk_bypass_idle: assert property (
		ce && bus_passthrough && !host_busy |=> !host_busy)
		else $error("host started in passthrough");
	chk_dir_first: assert property (
		xfer_start && !xfer_index
		|-> xfer_read == cfg_reg[ihc_pkg::B_DIR_LO])
		else $error("first direction wrong");
	chk_reserved_zero: assert property (
		(dev_reg & ~ihc_pkg::MASK_DEV_CTRL) == 24'h000000
		&& (cfg_reg & ~ihc_pkg::MASK_HOST_CFG) == 24'h000000)
		else $error("reserved bits set");
	chk_one_trans: assert property (
		xfer_start && xfer_index |-> xfr_reg[ihc_pkg::B_NUM_TRAN])
		else $error("second transaction in single mode");
	chk_eeprom_addr: assert property (
		reg_wr && ce && reg_addr == ihc_pkg::OFF_HOST_CFG && !srst_reg
		|=> eeprom_addr
		== $past(reg_wdata[ihc_pkg::B_EE_ADDR_HI:ihc_pkg::B_EE_ADDR_LO]))
		else $error("eeprom address mismatch");
	chk_burst_out: assert property (
		reg_wr && ce && reg_addr == ihc_pkg::OFF_DEV_CTRL
		&& !reg_wdata[ihc_pkg::B_SOFT_RST] && !srst_reg
		|=> burst_register_access == $past(reg_wdata[ihc_pkg::B_BURST]))
		else $error("burst bit not taken");

	cov_manual_seq: cover property (
		!cfg_reg[ihc_pkg::B_SAMPLE_TRIG] && trig_pulse && allowed
		##[1:4] xfer_start);
	cov_sample_seq: cover property (
		cfg_reg[ihc_pkg::B_SAMPLE_TRIG] && sample_start && allowed
		##[1:4] xfer_start);
	cov_two_trans: cover property (xfer_start && xfer_index);
	cov_soft_reset: cover property (srst_reg);
endmodule
`default_nettype wire

// >>> ihc_far_model.sv
// host bus engine and capture core model
`timescale 1ns/10ps
`default_nettype none
module ihc_far_model #(
	parameter int DLY = 8
) (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       xfer_start,
	input  wire logic       capture_start,
	input  wire logic [7:0] rd_byte,
	output logic            xfer_done,
	output logic [7:0]      xfer_rdata,
	output logic            capture_done
);
	int         xcnt;
	int         ccnt;
	logic [7:0] last;
	// done only after a start, byte valid with done only
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			xcnt <= 0;
			ccnt <= 0;
			xfer_done <= 1'b0;
			capture_done <= 1'b0;
			last <= 8'h00;
		end else begin
			xfer_done <= (xcnt == 1);
			capture_done <= (ccnt == 1);
			if (xcnt == 1)
				last <= rd_byte;
			xcnt <= xfer_start ? DLY : (xcnt != 0 ? xcnt - 1 : 0);
			ccnt <= capture_start ? DLY : (ccnt != 0 ? ccnt - 1 : 0);
		end
	end
	assign xfer_rdata = xfer_done ? last : ~last;
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench for the control registers
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        mclk = 0, rst = 1, ce = 1;
	logic        wr = 0, rd = 0, sst = 0;
	logic [7:0]  addr = 8'h00, xdata, byte_in = 8'h00;
	logic [23:0] wdata = 24'h000000, rdata;
	logic        cdone, xdone, cst, srst, burst, frc, pass;
	logic        xst, xrd, xidx, busy;
	logic [6:0]  eaddr;
	logic [3:0]  hist = 4'h0;
	int          bad_count = 0, n_compared = 0, cyc = 0;
	int          n_start = 0, n_cap = 0, n_srst = 0, n;

	ihc_ctrl_regs dut (.mclk(mclk), .rst(rst), .ce(ce),
		.reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
		.reg_rd(rd), .sample_start(sst), .capture_done(cdone),
		.xfer_done(xdone), .xfer_rdata(xdata), .reg_rdata(rdata),
		.capture_start(cst), .soft_reset_out(srst),
		.burst_register_access(burst), .force_local_access(frc),
		.bus_passthrough(pass), .eeprom_addr(eaddr),
		.xfer_start(xst), .xfer_read(xrd), .xfer_index(xidx),
		.host_busy(busy));
	ihc_far_model far (.mclk(mclk), .rst(rst), .xfer_start(xst),
		.capture_start(cst), .rd_byte(byte_in), .xfer_done(xdone),
		.xfer_rdata(xdata), .capture_done(cdone));

	always #10 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (xst === 1'b1) begin
			n_start++;
			hist <= {hist[1:0], xidx, xrd};
		end
		if (cst === 1'b1)
			n_cap++;
		if (srst === 1'b1)
			n_srst++;
		if (cyc == 3000) begin
			bad_count++;
			stop_test();
		end
	end

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic idle(input int c);
		repeat (c) @(posedge mclk);
		#2;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [23:0] d);
		idle(1);
		addr = a;
		wdata = d;
		wr = 1;
		idle(1);
		wr = 0;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [23:0] e);
		idle(1);
		addr = a;
		rd = 1;
		idle(1);
		rd = 0;
		idle(1);
		chk(rdata, e);
	endtask
	task automatic t_reset();
		rreg(8'h00, 24'h000000);
		rreg(8'h01, 24'h120140);
		chk(24'(eaddr), 24'h000050);
		rreg(8'h03, 24'h000000);
	endtask
	task automatic t_mask();
		wreg(8'h00, 24'h7FFFFE);
		rreg(8'h00, 24'h600040);
		chk({21'h0, frc, pass, burst}, 24'h000007);
		rreg(8'h05, 24'h000000);
		wreg(8'h00, 24'h000000);
		chk({21'h0, frc, pass, burst}, 24'h000000);
	endtask
	task automatic t_cap();
		n = n_cap;
		wreg(8'h00, 24'h800000);
		rreg(8'h00, 24'h800000);
		chk(24'(n_cap - n), 24'h000001);
		idle(10);
		rreg(8'h00, 24'h000000);
	endtask
	task automatic t_man();
		byte_in = 8'h01;
		n = n_start;
		wreg(8'h01, 24'h1C00AA);
		idle(30);
		chk(24'(n_start - n), 24'h000001);
		chk(24'(hist[1:0]), 24'h000001);
		chk(24'(eaddr), 24'h00002A);
		rreg(8'h03, 24'h000080);
	endtask
	task automatic t_two();
		byte_in = 8'hC3;
		wreg(8'h03, 24'h020000);
		n = n_start;
		wreg(8'h01, 24'h2C0140);
		idle(40);
		chk(24'(n_start - n), 24'h000002);
		chk(24'(hist), 24'h000003);
		rreg(8'h03, 24'h0200C3);
		wreg(8'h03, 24'h000000);
	endtask
	task automatic t_block();
		n = n_start;
		wreg(8'h00, 24'h200000);
		wreg(8'h01, 24'h1C0140);
		idle(30);
		chk(24'(n_start - n), 24'h000000);
		wreg(8'h00, 24'h000000);
		wreg(8'h01, 24'h140140);
		idle(30);
		chk(24'(n_start - n), 24'h000000);
	endtask
	task automatic t_sample();
		n = n_start;
		wreg(8'h01, 24'h1A0140);
		sst = 1;
		idle(1);
		sst = 0;
		chk(24'(busy), 24'h000001);
		idle(30);
		chk(24'(n_start - n), 24'h000001);
		chk(24'(busy), 24'h000000);
	endtask
	task automatic t_srst();
		n = n_srst;
		wreg(8'h00, 24'h000041);
		idle(3);
		chk(24'(n_srst - n), 24'h000001);
		rreg(8'h00, 24'h000000);
		rreg(8'h01, 24'h120140);
		rreg(8'h03, 24'h000000);
	endtask
	task automatic t_ce();
		ce = 0;
		wreg(8'h00, 24'h000040);
		chk(24'(burst), 24'h000000);
		ce = 1;
		rreg(8'h00, 24'h000000);
	endtask
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		idle(2);
		rst = 0;
		t_reset();
		t_mask();
		t_cap();
		t_man();
		t_two();
		t_block();
		t_sample();
		t_srst();
		t_ce();
		stop_test();
	end
endmodule
`default_nettype wire
